// ---- core/pkim_defines.vh ----
`ifndef PKIM_DEFINES_VH
`define PKIM_DEFINES_VH
`define PKIM_ADDR_W 4
`define PKIM_OFF_CTRL 4'h0
`define PKIM_OFF_STATUS 4'h1
`define PKIM_OFF_MASK 4'h2
`define PKIM_OFF_EXP 4'h3
`define PKIM_OFF_PC 4'h4
`define PKIM_OFF_IRQ_EN 4'h5
`define PKIM_OFF_IRQ_CLR 4'h6
`define PKIM_OFF_IRQ_STAT 4'h7
`define PKIM_MASK_IMPL 16'h0015
`define PKIM_MASK_RESET 16'h0000
`define PKIM_BIT_DONE 0
`define PKIM_BIT_OOR 2
`define PKIM_BIT_ERDY 4
`define PKIM_CTRL_IE 0
`define PKIM_CTRL_START 1
`define PKIM_BOOT_CYCLES 12'h080
`define PKIM_WORD_CYCLES 8'h10
`define PKIM_IRQ_LAT 2
`endif

// ---- core/pkim_boot_seq.v ----
`timescale 1ns/1ps
`include "pkim_defines.vh"
module pkim_boot_seq #(
  parameter BOOT_CYCLES = `PKIM_BOOT_CYCLES
) (
  input wire ref_clk,
  input wire rstn,
  output reg busy_q,
  output reg done_pulse_q
);
  reg [11:0] cnt_q;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b1;
      done_pulse_q <= 1'b0;
    end else begin
      done_pulse_q <= 1'b0;
      if (busy_q) begin
        // ram clear sweep stands in as a counter
        if (cnt_q == BOOT_CYCLES - 12'h001) begin
          busy_q <= 1'b0;
          done_pulse_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 12'h001;
        end
      end
    end
  end
endmodule

// ---- core/pkim_exp_buf.v ----
`timescale 1ns/1ps
`include "pkim_defines.vh"
module pkim_exp_buf #(
  parameter WORD_CYCLES = `PKIM_WORD_CYCLES
) (
  input wire ref_clk,
  input wire rstn,
  input wire run,
  input wire wr,
  input wire [31:0] wdata,
  output reg req_q,
  output reg [31:0] work_q
);
  reg [31:0] hold_q;
  reg hold_v_q;
  reg work_v_q;
  reg [7:0] use_q;
  wire consume;
  assign consume = work_v_q && (use_q == WORD_CYCLES - 8'h01);
  always @(posedge ref_clk) begin
    if (!rstn) begin
      hold_q <= 32'h00000000;
      hold_v_q <= 1'b0;
      work_q <= 32'h00000000;
      work_v_q <= 1'b0;
      use_q <= 8'h00;
      req_q <= 1'b0;
    end else begin
      if (wr) begin
        hold_q <= wdata;
        hold_v_q <= 1'b1;
      end else if ((!work_v_q || consume) && hold_v_q) begin
        hold_v_q <= 1'b0;
      end
      // two stages so the host has a full word time to answer
      if ((!work_v_q || consume) && hold_v_q) begin
        work_q <= hold_q;
        work_v_q <= 1'b1;
        use_q <= 8'h00;
      end else if (consume) begin
        work_v_q <= 1'b0;
        use_q <= 8'h00;
      end else if (work_v_q) begin
        use_q <= use_q + 8'h01;
      end
      req_q <= run && !hold_v_q && !wr;
    end
  end
endmodule

// ---- core/pkim_top.v ----
// Overview of operation
// - irq_q follows status changes only while global enable is set; evt_irq_q ignores it
// - a mask bit of one stops its status bit from driving irq_q; evt_irq_q is not masked
// - host may read and write the mask register
// - mask read returns bits 15:0, upper data half zero, unused bits zero
// - mask bit 4 gates the exponent word request condition
// - exponent input write clears the request and its irq_q share; its evt_irq_q event stays set until cleared
// - interrupt drops about two cycles after the exponent write
// - exponent input is double buffered, giving the host slack
// - unknown or reserved address access sets out of range status
// - routine complete sets when execution branches to location zero
// - after reset boot clears ram, stays busy, then sets routine complete
// - writing the status location clears every status bit except one that is being set in the same cycle
// - status interrupt flag mirrors the condition regardless of global enable
`timescale 1ns/1ps
`include "pkim_defines.vh"
module pkim_top #(
  parameter BOOT_CYCLES = `PKIM_BOOT_CYCLES,
  parameter WORD_CYCLES = `PKIM_WORD_CYCLES,
  parameter ROUTINE_CYCLES = 8'h40
) (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_q,
  output reg irq_q,
  output reg busy_q,
  output reg evt_irq_q
);
  reg [15:0] mask_q;
  reg [15:0] ctrl_q;
  reg [15:0] stat_q;
  reg [10:0] pc_q;
  reg [7:0] run_cnt_q;
  reg running_q;
  reg [2:0] evt_en_q;
  reg [2:0] evt_st_q;
  reg irq_pre_q;
  reg [31:0] rdata_d;
  wire boot_busy;
  wire boot_done;
  wire erdy_req;
  wire [31:0] exp_word;
  wire known;
  wire exp_wr;
  wire stat_wr;
  wire branch0;
  wire [15:0] stat_set;
  wire [15:0] stat_next;
  wire cond;
  wire [2:0] evt_set;

  function is_known;
    input [3:0] a;
    begin
      is_known = (a <= `PKIM_OFF_IRQ_STAT);
    end
  endfunction

  pkim_boot_seq #(
    .BOOT_CYCLES(BOOT_CYCLES)
  ) u_boot (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .busy_q(boot_busy),
    .done_pulse_q(boot_done)
  );

  pkim_exp_buf #(
    .WORD_CYCLES(WORD_CYCLES)
  ) u_exp (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(running_q),
    .wr(exp_wr),
    .wdata(wdata),
    .req_q(erdy_req),
    .work_q(exp_word)
  );

  assign known = is_known(addr);
  assign exp_wr = wr_stb && (addr == `PKIM_OFF_EXP);
  assign stat_wr = wr_stb && (addr == `PKIM_OFF_STATUS);
  assign branch0 = running_q && (run_cnt_q == ROUTINE_CYCLES - 8'h01);

  assign stat_set = {11'h000,
                     erdy_req && !exp_wr,
                     1'b0,
                     (wr_stb || rd_stb) && !known,
                     1'b0,
                     boot_done || branch0};
  // set wins over clear for every flag except bit 4, where an exponent write clear wins
  assign stat_next = ((stat_wr ? 16'h0000 : stat_q) &
                      ~({11'h000, exp_wr, 4'h0})) | stat_set;
  assign cond = |(stat_q & ~mask_q & `PKIM_MASK_IMPL);
  assign evt_set = {stat_set[`PKIM_BIT_ERDY] & ~stat_q[`PKIM_BIT_ERDY],
                    stat_set[`PKIM_BIT_OOR], stat_set[`PKIM_BIT_DONE]};

  always @(posedge ref_clk) begin
    if (!rstn) begin
      mask_q <= `PKIM_MASK_RESET;
      ctrl_q <= 16'h0000;
      stat_q <= 16'h0000;
      pc_q <= 11'h000;
      run_cnt_q <= 8'h00;
      running_q <= 1'b0;
      evt_en_q <= 3'h0;
      evt_st_q <= 3'h0;
      irq_pre_q <= 1'b0;
      irq_q <= 1'b0;
      busy_q <= 1'b1;
      evt_irq_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      if (wr_stb && addr == `PKIM_OFF_MASK) begin
        mask_q <= wdata[15:0] & `PKIM_MASK_IMPL;
      end
      if (wr_stb && addr == `PKIM_OFF_CTRL) begin
        ctrl_q <= wdata[15:0];
      end
      if (wr_stb && addr == `PKIM_OFF_PC) begin
        pc_q <= wdata[10:0];
      end
      if (wr_stb && addr == `PKIM_OFF_IRQ_EN) begin
        evt_en_q <= wdata[2:0];
      end
      evt_st_q <= (evt_st_q & ~((wr_stb && addr == `PKIM_OFF_IRQ_CLR) ?
                  wdata[2:0] : 3'h0)) | evt_set;
      stat_q <= stat_next;
      if (!boot_busy && !running_q && wr_stb && addr == `PKIM_OFF_CTRL &&
          wdata[`PKIM_CTRL_START]) begin
        running_q <= 1'b1;
        run_cnt_q <= 8'h00;
      end else if (branch0) begin
        running_q <= 1'b0;
        pc_q <= 11'h000;
      end else if (running_q) begin
        run_cnt_q <= run_cnt_q + 8'h01;
        pc_q <= pc_q + 11'h001;
      end
      // two stage path gives the two cycle drop after an exponent write
      irq_pre_q <= cond;
      irq_q <= irq_pre_q && ctrl_q[`PKIM_CTRL_IE];
      busy_q <= boot_busy || running_q;
      evt_irq_q <= |(evt_st_q & evt_en_q);
      rdata_q <= rdata_d;
    end
  end

  always @* begin
    rdata_d = 32'h00000000;
    if (rd_stb) begin
      case (addr)
        `PKIM_OFF_CTRL: rdata_d = {16'h0000, ctrl_q};
        // irq flag in bit 12 ignores global enable
        `PKIM_OFF_STATUS: rdata_d = {16'h0000, stat_q[15:13], irq_pre_q,
                                     stat_q[11:0]};
        `PKIM_OFF_MASK: rdata_d = {16'h0000, mask_q & `PKIM_MASK_IMPL};
        `PKIM_OFF_EXP: rdata_d = exp_word;
        `PKIM_OFF_PC: rdata_d = {21'h00000, pc_q};
        `PKIM_OFF_IRQ_EN: rdata_d = {29'h0000000, evt_en_q};
        `PKIM_OFF_IRQ_STAT: rdata_d = {29'h0000000, evt_st_q};
        // unknown addresses read zero; host must not trust it
        default: rdata_d = 32'h00000000;
      endcase
    end
  end
endmodule

// ---- dv/pkim_host.sv ----
`timescale 1ns/1ps
`include "pkim_defines.vh"
module pkim_host (
  input wire ref_clk,
  input wire [31:0] rdata_q,
  output reg [3:0] addr = 4'h0,
  output reg [31:0] wdata = 32'h0,
  output reg wr_stb = 1'b0,
  output reg rd_stb = 1'b0
);
  // gap cycle after each strobe keeps one driver per step
  task wr(input [3:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= (a == `PKIM_OFF_MASK) ? d & `PKIM_MASK_IMPL : d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // data of an unknown address is taken but never trusted
  task rd(input [3:0] a, output [31:0] d);
    begin
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      @(posedge ref_clk);
      d = rdata_q;
    end
  endtask
endmodule

// ---- dv/pkim_chk_assertions.sv ----
`timescale 1ns/1ps
`include "pkim_defines.vh"
module pkim_chk (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata_q,
  input wire irq_q,
  input wire busy_q
);
  reg ie_q;
  reg [15:0] m_q;
  wire mrd = rd_stb && addr == `PKIM_OFF_MASK;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      ie_q <= 1'b0;
      m_q <= 16'h0000;
    end else if (wr_stb) begin
      if (addr == `PKIM_OFF_CTRL) ie_q <= wdata[0];
      if (addr == `PKIM_OFF_MASK) m_q <= wdata[15:0] & `PKIM_MASK_IMPL;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence st_wr; wr_stb && addr == `PKIM_OFF_STATUS && !busy_q; endsequence
  sequence oor_acc; (wr_stb || rd_stb) && addr > 4'h7 && ie_q && !m_q[2]; endsequence
  mask_rd_a: assert property ($past(mrd) |-> rdata_q == {16'h0, $past(m_q)})
    else $error("mask read");
  ie_off_a: assert property ((!ie_q)[*3] |-> !irq_q)
    else $error("irq without enable");
  mask_all_a: assert property ((m_q == `PKIM_MASK_IMPL)[*3] |-> !irq_q)
    else $error("irq while masked");
  // a write in the two cycles before may already have started the drop
  exp_lat_a: assert property (wr_stb && addr == `PKIM_OFF_EXP && irq_q &&
    !$past(wr_stb) && !$past(wr_stb, 2) |=> irq_q ##1 irq_q)
    else $error("irq fell early");
  st_clr_a: assert property (st_wr ##1 (!wr_stb && !rd_stb)[*2] |=> !irq_q)
    else $error("status not cleared");
  oor_a: assert property (oor_acc |-> ##[1:3] irq_q)
    else $error("no range irq");
  done_a: assert property ($fell(busy_q) && ie_q && !m_q[0] |-> ##[0:4] irq_q)
    else $error("no done irq");
  boot_a: assert property ($rose(rstn) |-> busy_q[*4])
    else $error("boot not busy");
endmodule
bind pkim_top pkim_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .irq_q(irq_q), .busy_q(busy_q));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "pkim_defines.vh"
module tb_top;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  wire [3:0] addr;
  wire [31:0] wdata;
  wire [31:0] rdata_q;
  wire wr_stb, rd_stb, irq_q, busy_q, evt_irq_q;
  reg [31:0] d;
  integer errors = 0;
  integer compares = 0;
  initial forever #50 ref_clk = ~ref_clk;
  pkim_top #(.BOOT_CYCLES(12'h008)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .irq_q(irq_q),
    .busy_q(busy_q), .evt_irq_q(evt_irq_q));
  pkim_host i_host (.ref_clk(ref_clk), .rdata_q(rdata_q), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));
  task stop_test;
    begin
      if (errors == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task rc(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      i_host.rd(a, d);
      chk(d & m, e);
    end
  endtask
  // bounded wait on irq (s=1) or busy (s=0)
  task wl(input s, input v);
    integer n;
    begin
      for (n = 0; n < 500 && (s ? irq_q : busy_q) !== v; n = n + 1) begin
        @(posedge ref_clk);
      end
      if ((s ? irq_q : busy_q) !== v) begin
        chk(0, 1);
        stop_test;
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    chk({busy_q, irq_q}, 2'b10);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rc(`PKIM_OFF_MASK, 32'hFFFFFFFF, 32'h0);
    wl(0, 0);
    rc(`PKIM_OFF_STATUS, 32'h1001, 32'h1001);
    chk(irq_q, 0);
    i_host.wr(`PKIM_OFF_CTRL, 32'h1);
    wl(1, 1);
    // clear while an unmasked bit drives irq, so the drop is real
    i_host.wr(`PKIM_OFF_STATUS, 32'h0);
    repeat (2) @(posedge ref_clk);
    rc(`PKIM_OFF_STATUS, 32'h1015, 32'h0);
    chk(irq_q, 0);
    i_host.wr(`PKIM_OFF_MASK, 32'hFFFF);
    rc(`PKIM_OFF_MASK, 32'hFFFFFFFF, 32'h15);
    i_host.rd(4'hF, d);
    repeat (2) @(posedge ref_clk);
    chk(irq_q, 0);
    i_host.wr(`PKIM_OFF_MASK, 32'h0);
    wl(1, 1);
    i_host.wr(`PKIM_OFF_STATUS, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq_q, 0);
    i_host.rd(4'hF, d);
    wl(1, 1);
    chk(evt_irq_q, 0);
    i_host.wr(4'h5, 32'h7);
    rc(`PKIM_OFF_STATUS, 32'h4, 32'h4);
    chk(evt_irq_q, 1);
    i_host.wr(4'h6, 32'h7);
    @(posedge ref_clk);
    chk(evt_irq_q, 0);
    rc(`PKIM_OFF_IRQ_STAT, 32'h7, 32'h0);
    i_host.wr(`PKIM_OFF_STATUS, 32'h0);
    i_host.wr(`PKIM_OFF_MASK, 32'h5);
    i_host.wr(`PKIM_OFF_CTRL, 32'h3);
    wl(1, 1);
    i_host.wr(`PKIM_OFF_EXP, 32'h1);
    i_host.wr(`PKIM_OFF_EXP, 32'h2);
    repeat (2) @(posedge ref_clk);
    rc(`PKIM_OFF_STATUS, 32'h10, 32'h0);
    chk(irq_q, 0);
    wl(1, 1);
    rc(`PKIM_OFF_EXP, 32'hFFFFFFFF, 32'h2);
    rc(`PKIM_OFF_IRQ_STAT, 32'h4, 32'h4);
    chk(evt_irq_q, 1);
    i_host.wr(`PKIM_OFF_MASK, 32'h14);
    repeat (2) @(posedge ref_clk);
    chk(irq_q, 0);
    wl(0, 0);
    rc(`PKIM_OFF_STATUS, 32'h1, 32'h1);
    rc(`PKIM_OFF_PC, 32'h7FF, 32'h0);
    stop_test;
  end
endmodule
